// file: card_seq_pkg.sv
/*
  Shared constants and types for the card socket power sequencer, and the
  small card presence filter that the sequencer instantiates.
  Assumes one 200 MHz clock, an asynchronous active-low reset and card-detect
  inputs that are already synchronous to that clock.
*/
// How it works
// - Never pass the set-feature command that selects 8-bit transfers.
// - A card counts as inserted only when both detect inputs read low together.
// - Socket power control is active low: low is on, high is off.
// - After our own reset, switch socket power on.
// - On insertion, switch socket power off about one second, then on.
// - Repeat the power cycle on every removal and reinsertion.
// - Sequencing holds only when the card is alone on its bus.
// - Issue identify to learn capabilities and then set a matching transfer mode.
package card_seq_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned POWER_OFF_TIME_MS = 1000;
  localparam int unsigned POWER_OFF_CYCLES = POWER_OFF_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DETECT_STABLE_CYCLES = 16;
  localparam int unsigned RESET_HOLD_CYCLES = 64;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned XFER_MODE_W = 3;
  localparam logic [XFER_MODE_W-1:0] XFER_MODE_RESET = 3'h0;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] FEAT_ENABLE_8BIT = 8'h01;
  localparam logic POWER_ON = 1'b0;
  localparam logic POWER_OFF = 1'b1;

  typedef enum logic [2:0] {
    S_BOOT,
    S_IDLE,
    S_OFF,
    S_RESET,
    S_IDENT,
    S_READY,
    S_SHARED
  } seq_state_e;
endpackage : card_seq_pkg

`timescale 1ns/1ps

module card_presence_filter #(
  parameter int unsigned STABLE_CYCLES = card_seq_pkg::DETECT_STABLE_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_card_detect_a_n,
  input wire logic i_card_detect_b_n,
  output logic o_present,
  output logic o_inserted,
  output logic o_removed
);
  import card_seq_pkg::*;

  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

  typedef struct packed {
    logic present;
    logic [CW-1:0] count;
    logic inserted;
    logic removed;
  } filt_s;

  filt_s st;
  filt_s next_st;
  logic both_low;

  // Both pins must read low in the same cycle; one pin alone is a half-seated card.
  assign both_low = !i_card_detect_a_n && !i_card_detect_b_n;

  // A change must hold for the whole window, so contact bounce never flips presence.
  always_comb begin
    next_st = st;
    next_st.inserted = 1'b0;
    next_st.removed = 1'b0;
    if (both_low == st.present) begin
      next_st.count = '0;
    end else if (st.count == CW'(STABLE_CYCLES - 1)) begin
      next_st.count = '0;
      next_st.present = both_low;
      next_st.inserted = both_low;
      next_st.removed = !both_low;
    end else begin
      next_st.count = st.count + CW'(1);
    end
  end

  // State register.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_present = st.present;
  assign o_inserted = st.inserted;
  assign o_removed = st.removed;

  a_present_both_low: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $rose(st.present) |-> $past(both_low, 1) && $past(both_low, 2))
    else $error("Presence rose without both detect pins low.");
endmodule : card_presence_filter

// file: card_socket_power_sequencer.sv
/*
  Card socket power sequencer: switches the socket supply so an inserted card
  comes up as a disk, holds the drive in reset, runs identify, and gates
  command traffic to the card until the sequence is complete.
  Assumes a sole card on its bus, inputs synchronous to i_ref_clk, and an
  outside ATA engine that performs identify and executes passed commands.
*/
`timescale 1ns/1ps

module card_socket_power_sequencer #(
  parameter int unsigned OFF_CYCLES = card_seq_pkg::POWER_OFF_CYCLES,
  parameter int unsigned HOLD_CYCLES = card_seq_pkg::RESET_HOLD_CYCLES,
  parameter int unsigned STABLE_CYCLES = card_seq_pkg::DETECT_STABLE_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_card_detect_a_n,
  input wire logic i_card_detect_b_n,
  input wire logic i_shared_bus,
  input wire logic i_identify_done,
  input wire logic [card_seq_pkg::XFER_MODE_W-1:0] i_identify_mode,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic [7:0] i_cmd_feature,
  output logic o_socket_power_ctl_n,
  output logic o_drive_reset_out_n,
  output logic o_identify_req,
  output logic [card_seq_pkg::XFER_MODE_W-1:0] o_xfer_mode,
  output logic o_card_ready,
  output logic o_unsupported_bus,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_opcode,
  output logic [7:0] o_cmd_feature,
  output logic o_cmd_rejected
);
  import card_seq_pkg::*;

  typedef struct packed {
    seq_state_e state;
    logic power_n;
    logic drive_reset_n;
    logic [CNT_W-1:0] count;
    logic identify_req;
    logic [XFER_MODE_W-1:0] xfer_mode;
    logic ready;
    logic unsupported;
    logic cmd_valid;
    logic [7:0] cmd_opcode;
    logic [7:0] cmd_feature;
    logic cmd_rejected;
  } seq_s;

  seq_s st;
  seq_s next_st;
  logic present;
  logic inserted;
  logic removed;
  logic bad_cmd;

  card_presence_filter #(
    .STABLE_CYCLES(STABLE_CYCLES)
  ) u_presence (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_card_detect_a_n(i_card_detect_a_n),
    .i_card_detect_b_n(i_card_detect_b_n),
    .o_present(present),
    .o_inserted(inserted),
    .o_removed(removed)
  );

  // The 8-bit width select is never forwarded, so the wide-cycle pin can stay open.
  assign bad_cmd = (i_cmd_opcode == CMD_SET_FEATURES)
                   && (i_cmd_feature == FEAT_ENABLE_8BIT);

  // Sequencer: power, drive reset, identify, then traffic gate.
  always_comb begin
    next_st = st;
    next_st.identify_req = 1'b0;
    next_st.cmd_valid = 1'b0;
    next_st.cmd_rejected = 1'b0;
    next_st.cmd_opcode = i_cmd_opcode;
    next_st.cmd_feature = i_cmd_feature;
    case (st.state)
      S_BOOT: begin
        // Reset leaves the socket off; the first edge after release turns it on.
        next_st.power_n = POWER_ON;
        next_st.state = S_IDLE;
      end
      S_IDLE: begin
        next_st.ready = 1'b0;
        next_st.drive_reset_n = 1'b0;
        if (i_shared_bus) begin
          // A second drive on the bus needs another scheme, so stay out of the way.
          next_st.unsupported = 1'b1;
          next_st.state = S_SHARED;
        end else if (present) begin
          // The card woke in card-bus mode; a full supply cycle makes it latch disk mode.
          next_st.power_n = POWER_OFF;
          next_st.count = '0;
          next_st.state = S_OFF;
        end
      end
      S_OFF: begin
        // The off time runs on our own clock counter.
        if (st.count == CNT_W'(OFF_CYCLES - 1)) begin
          next_st.power_n = POWER_ON;
          next_st.count = '0;
          next_st.state = S_RESET;
        end else begin
          next_st.count = st.count + CNT_W'(1);
        end
      end
      S_RESET: begin
        // Hold the drive in reset a little after power returns so the supply settles.
        if (!present) begin
          next_st.state = S_IDLE;
        end else if (st.count == CNT_W'(HOLD_CYCLES - 1)) begin
          next_st.drive_reset_n = 1'b1;
          next_st.identify_req = 1'b1;
          next_st.state = S_IDENT;
        end else begin
          next_st.count = st.count + CNT_W'(1);
        end
      end
      S_IDENT: begin
        if (!present) begin
          next_st.drive_reset_n = 1'b0;
          next_st.state = S_IDLE;
        end else if (i_identify_done) begin
          next_st.xfer_mode = i_identify_mode;
          next_st.ready = 1'b1;
          next_st.state = S_READY;
        end
      end
      S_READY: begin
        if (removed || !present) begin
          // Power stays on; the next insertion runs the whole cycle again.
          next_st.ready = 1'b0;
          next_st.drive_reset_n = 1'b0;
          // A command offered in the removal cycle is refused rather than silently lost.
          next_st.cmd_rejected = i_cmd_valid;
          next_st.state = S_IDLE;
        end else if (i_cmd_valid) begin
          next_st.cmd_valid = !bad_cmd;
          next_st.cmd_rejected = bad_cmd;
        end
      end
      S_SHARED: begin
        // Left only by a reset, since the bus arrangement is a board property.
        next_st.ready = 1'b0;
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase
    // Commands offered before the card is ready are refused, not queued.
    if (i_cmd_valid && st.state != S_READY) begin
      next_st.cmd_rejected = 1'b1;
    end
  end

  // State register; the socket starts switched off.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{state: S_BOOT, power_n: POWER_OFF, drive_reset_n: 1'b0, count: '0,
              identify_req: 1'b0, xfer_mode: XFER_MODE_RESET, ready: 1'b0,
              unsupported: 1'b0, cmd_valid: 1'b0, cmd_opcode: 8'h00,
              cmd_feature: 8'h00, cmd_rejected: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_socket_power_ctl_n = st.power_n;
  assign o_drive_reset_out_n = st.drive_reset_n;
  assign o_identify_req = st.identify_req;
  assign o_xfer_mode = st.xfer_mode;
  assign o_card_ready = st.ready;
  assign o_unsupported_bus = st.unsupported;
  assign o_cmd_valid = st.cmd_valid;
  assign o_cmd_opcode = st.cmd_opcode;
  assign o_cmd_feature = st.cmd_feature;
  assign o_cmd_rejected = st.cmd_rejected;

  // Length of the current power-off stretch, read only by the checks below.
  logic [CNT_W-1:0] off_run;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      off_run <= '0;
    end else if (st.power_n == POWER_OFF) begin
      off_run <= off_run + CNT_W'(1);
    end else begin
      off_run <= '0;
    end
  end

  a_power_on_ready: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st.ready |-> (st.power_n == POWER_ON))
    else $error("Card ready while socket power is off.");

  a_boot_power_on: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st.state == S_BOOT) |=> (st.power_n == POWER_ON) && (st.state == S_IDLE))
    else $error("Socket power not switched on after reset.");

  a_insert_power_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st.state == S_IDLE && present && !i_shared_bus) |=> (st.power_n == POWER_OFF))
    else $error("Insertion did not switch socket power off.");

  a_off_duration: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ($fell(st.power_n) && st.state == S_RESET) |-> (off_run == CNT_W'(OFF_CYCLES)))
    else $error("Power-off interval has the wrong length.");

  a_no_8bit_cmd: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st.cmd_valid |-> !(st.cmd_opcode == CMD_SET_FEATURES && st.cmd_feature == FEAT_ENABLE_8BIT))
    else $error("8-bit set-feature command passed to the card.");

  a_traffic_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    st.cmd_valid |-> ($past(st.state) == S_READY) && $past(i_cmd_valid))
    else $error("Command passed before the sequence completed.");

  a_reinsert_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st.state == S_READY && removed) |=> (st.state == S_IDLE) && !st.ready)
    else $error("Removal did not rearm the power cycle.");

  a_identify_mode: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st.state == S_IDENT && present && i_identify_done)
      |=> st.ready && (st.xfer_mode == $past(i_identify_mode)))
    else $error("Transfer mode not taken from identify result.");

  a_shared_blocked: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (st.state == S_SHARED) |-> !st.ready && st.unsupported && (st.power_n == POWER_ON))
    else $error("Shared bus was sequenced.");
endmodule : card_socket_power_sequencer

// file: card_model.sv
/*
  Behavioural card in its socket: detect contacts, supply-latched disk mode
  and identify answers for the power sequencer bench.
  Assumes the bench clock, socket pull-ups on both detect contacts and a mode
  strap grounded at the socket.
*/
`timescale 1ns/1ps

module card_model (
  input wire logic i_ref_clk,
  input wire logic i_inserted,
  input wire logic i_half,
  input wire logic i_power_ctl_n,
  input wire logic i_identify_req,
  input wire logic [2:0] i_mode,
  input wire logic [3:0] i_delay,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic [7:0] i_cmd_feature,
  output logic o_detect_a_n,
  output logic o_detect_b_n,
  output logic o_identify_done,
  output logic [2:0] o_identify_mode,
  output logic o_disk_mode,
  output logic o_narrow
);
  import card_seq_pkg::*;
  logic strap = 1'b0; // Mode strap grounded, so the card takes disk mode as the supply rises.
  logic was_on = 1'b0;
  logic disk = 1'b0;
  logic narrow = 1'b0;
  logic done = 1'b0;
  logic [2:0] mode = 3'h5;
  int wait_cnt = -1;

  // A seated contact grounds its pin; a missing one is lifted by the pull-up.
  assign o_detect_a_n = !(i_inserted || i_half);
  assign o_detect_b_n = !i_inserted;
  assign o_identify_done = done;
  assign o_identify_mode = mode;
  assign o_disk_mode = disk;
  assign o_narrow = narrow;

  // Disk mode is taken only as the supply rises with the strap low.
  always @(posedge i_ref_clk) begin
    was_on <= !i_power_ctl_n;
    if (i_power_ctl_n || !i_inserted) begin
      disk <= 1'b0;
    end else if (!was_on) begin
      disk <= !strap;
    end
  end

  // Data stays 16 bits wide unless the 8-bit set-feature reaches the card in disk mode.
  // The wide-cycle pin is left open, so a narrow card would be unusable.
  always @(posedge i_ref_clk) begin
    if (i_power_ctl_n) begin
      narrow <= 1'b0;
    end else if (disk && i_cmd_valid && i_cmd_opcode == CMD_SET_FEATURES
                 && i_cmd_feature == FEAT_ENABLE_8BIT) begin
      narrow <= 1'b1;
    end
  end

  // Only a card in disk mode answers identify.
  // Between answers the mode lines churn so a stale value is never trusted.
  always @(posedge i_ref_clk) begin
    done <= 1'b0;
    mode <= ~mode;
    if (i_identify_req && disk) begin
      wait_cnt <= i_delay;
    end else if (wait_cnt == 0) begin
      done <= 1'b1;
      mode <= i_mode;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : card_model

// file: tb.sv
/*
  Self-checking bench for the card socket power sequencer with a card model.
  Assumes short sequencer counts for simulation and a 200 MHz clock.
*/
`timescale 1ns/1ps

module tb;
  import card_seq_pkg::*;
  localparam int unsigned OFF = 50;
  localparam int unsigned HOLD = 4;
  localparam int unsigned STAB = 3;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ins = 1'b0;
  logic half = 1'b0;
  logic shared = 1'b0;
  logic cv = 1'b0;
  logic [7:0] op = 8'h00;
  logic [7:0] ft = 8'h00;
  logic [2:0] imode = 3'h0;
  logic [3:0] idly = 4'h0;
  logic det_a_n, det_b_n, idone, ireq, pwr_n, drst_n, rdy, unsup, ocv, orej, disk;
  logic narrow;
  logic [2:0] idmode, xmode;
  logic [7:0] oop, oft;
  int bad_count = 0;
  int total_checks = 0;

  card_socket_power_sequencer #(.OFF_CYCLES(OFF), .HOLD_CYCLES(HOLD), .STABLE_CYCLES(STAB))
    u_card_socket_power_sequencer (.i_ref_clk(clk), .i_resetn(resetn),
    .i_card_detect_a_n(det_a_n), .i_card_detect_b_n(det_b_n), .i_shared_bus(shared),
    .i_identify_done(idone), .i_identify_mode(idmode), .i_cmd_valid(cv),
    .i_cmd_opcode(op), .i_cmd_feature(ft), .o_socket_power_ctl_n(pwr_n),
    .o_drive_reset_out_n(drst_n), .o_identify_req(ireq), .o_xfer_mode(xmode),
    .o_card_ready(rdy), .o_unsupported_bus(unsup), .o_cmd_valid(ocv),
    .o_cmd_opcode(oop), .o_cmd_feature(oft), .o_cmd_rejected(orej));

  card_model u_card_model (.i_ref_clk(clk), .i_inserted(ins), .i_half(half),
    .i_power_ctl_n(pwr_n), .i_identify_req(ireq), .i_mode(imode), .i_delay(idly),
    .i_cmd_valid(ocv), .i_cmd_opcode(oop), .i_cmd_feature(oft),
    .o_detect_a_n(det_a_n), .o_detect_b_n(det_b_n), .o_identify_done(idone),
    .o_identify_mode(idmode), .o_disk_mode(disk), .o_narrow(narrow));

  // Free-running reference clock.
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // A command is refused before the card is ready and for 8-bit set-feature.
  function automatic logic exp_reject(input logic ready, input logic [7:0] o, f);
    return !ready || (o == CMD_SET_FEATURES && f == FEAT_ENABLE_8BIT);
  endfunction : exp_reject

  // The bench says whether the card should be ready, so the design's flag is never trusted.
  task automatic send_cmd(input logic ready, input logic [7:0] o, input logic [7:0] f);
    logic rej;
    rej = exp_reject(ready, o, f);
    cv = 1'b1;
    op = o;
    ft = f;
    tick();
    check(ocv, !rej);
    check(orej, rej);
    check(oop, o);
    check(oft, f);
  endtask : send_cmd

  // Seat the card, then time the filter and the supply gap, and wait for identify.
  task automatic insert_cycle;
    int n;
    imode = 3'($urandom_range(7));
    idly = 4'($urandom_range(5));
    ins = 1'b1;
    n = 0;
    while (pwr_n !== 1'b1 && n < STAB + 6) begin
      tick();
      n++;
    end
    check(8'(n), 8'(STAB + 1));
    n = 0;
    while (pwr_n === 1'b1 && n < OFF + 10) begin
      check(rdy, 1'b0);
      check(drst_n, 1'b0);
      tick();
      n++;
    end
    check(8'(n), 8'(OFF));
    n = 0;
    while (rdy !== 1'b1 && n < HOLD + 40) begin
      tick();
      n++;
    end
    check(rdy, 1'b1);
    check(drst_n, 1'b1);
    check(xmode, imode);
    check(disk, 1'b1);
  endtask : insert_cycle

  // Main sequence: reset, false insertion, full sequence, commands, removals, shared bus.
  initial begin
    void'($urandom(32'h4FD0));
    repeat (2) @(posedge clk);
    #1;
    check(pwr_n, 1'b1);
    check(drst_n, 1'b0);
    resetn = 1'b1;
    tick();
    check(pwr_n, 1'b0);
    half = 1'b1;
    repeat (20) tick();
    check(pwr_n, 1'b0);
    half = 1'b0;
    send_cmd(1'b0, 8'h20, 8'h00);
    cv = 1'b0;
    insert_cycle();
    // Back-to-back commands, with the refused and the allowed set-feature among them.
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) send_cmd(1'b1, CMD_SET_FEATURES, FEAT_ENABLE_8BIT);
      else if (i % 8 == 4) send_cmd(1'b1, CMD_SET_FEATURES, 8'h02);
      else send_cmd(1'b1, 8'($urandom), 8'($urandom));
    end
    cv = 1'b0;
    ins = 1'b0;
    repeat (STAB + 4) tick();
    check(narrow, 1'b0);
    check(rdy, 1'b0);
    check(pwr_n, 1'b0);
    // Pulled out during the supply gap: the cycle is dropped once power returns.
    ins = 1'b1;
    repeat (STAB + 3) tick();
    check(pwr_n, 1'b1);
    ins = 1'b0;
    repeat (OFF + HOLD + 10) tick();
    check(rdy, 1'b0);
    check(pwr_n, 1'b0);
    check(drst_n, 1'b0);
    insert_cycle();
    // A mid-run reset with a second drive on the bus blocks the sequence for good.
    resetn = 1'b0;
    shared = 1'b1;
    repeat (2) tick();
    check(pwr_n, 1'b1);
    resetn = 1'b1;
    tick();
    check(pwr_n, 1'b0);
    repeat (STAB + 19) tick();
    check(unsup, 1'b1);
    check(rdy, 1'b0);
    check(pwr_n, 1'b0);
    complete_run();
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #(20000 * 5);
    bad_count++;
    complete_run();
  end
endmodule : tb
